// ==== stats_writer_defs.vh ====
// Shared constants of the statistics output writer
`ifndef STATS_WRITER_DEFS_VH
`define STATS_WRITER_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_STAT_DONE 8'h04
`define ADDR_STAT_ERR 8'h08
`define ADDR_BLKS_ROW 8'h0c
`define ADDR_ROWS 8'h10
`define ADDR_STATE 8'h14

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_UPD_BIT 1
`define STAT_FLAG_BIT 0
`define IRQ_ERR_BIT 0
`define IRQ_DONE_BIT 1
`define CTRL_RESET 2'h1
`define BLKS_ROW_RESET 8'h04
`define ROWS_RESET 8'h04

// ----------------------------------------
// Frame layout and timing counts
// ----------------------------------------
`define BLK_IN_WORDS 5'h10
`define BLK_OUT_WORDS 5'h11
`define TAIL_WORDS 11'h440
`define HDR_START 32'h5354_4152
`define HDR_FINAL 32'h454e_4421
`define BLK_TAG 16'h424b
`define HBLANK_MIN_CYCLES 10
`define VBLANK_MIN_LINES 3

`endif

// ==== stats_output_writer.v ====
// Statistics output writer with frame synchronisation and APB registers
//
// The address map and the APB register port were chosen for this implementation.
`include "stats_writer_defs.vh"

module stats_output_writer #(
  parameter COL_W = 2
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Video timing pin
  input wire vblank_pin,
  // Statistics processor results
  input wire stat_wr,
  input wire [31:0] stat_wdata,
  // Global statistics and histogram source
  input wire [31:0] glob_data,
  output reg [10:0] glob_idx,
  // Memory write port of the multiport_memory_controller
  input wire mem_wr_full,
  output reg mem_wr_en,
  output reg [31:0] mem_wr_data,
  // Frame flags
  output reg frame_done,
  output reg frame_error,
  output reg [1:0] irq_event,
  output reg reg_update_done
);

  localparam S_IDLE = 3'h0;
  localparam S_HDR = 3'h1;
  localparam S_BLK = 3'h2;
  localparam S_TAIL = 3'h3;
  localparam S_DONE = 3'h4;
  localparam DEPTH = 2 * (1 << COL_W) * 16;
  localparam IDX_W = COL_W + 5;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [1:0] ctrl;
  reg [7:0] blks_row;
  reg [7:0] rows;
  reg [7:0] blks_row_act;
  reg [7:0] rows_act;
  reg stat_done;
  reg stat_err;
  reg [2:0] state;
  reg frame_active;
  reg lost;
  reg [31:0] blk_buf [0:DEPTH-1];
  reg [3:0] wr_word;
  reg [COL_W-1:0] wr_col;
  reg wr_row;
  reg [15:0] wr_bcount;
  reg [4:0] rd_word;
  reg [COL_W-1:0] rd_col;
  reg rd_row;
  reg [15:0] rd_bcount;
  reg vbl_s1, vbl_s2, vbl_s3;
  reg vbl;

  // ----------------------------------------
  // Blanking pin synchroniser
  // ----------------------------------------
  wire vbl_agree = (vbl_s2 == vbl_s3);
  wire vbl_fall = vbl & vbl_agree & ~vbl_s3;
  wire vbl_rise = ~vbl & vbl_agree & vbl_s3;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbl_s1 <= 1'b0;
      vbl_s2 <= 1'b0;
      vbl_s3 <= 1'b0;
      vbl <= 1'b0;
    end else begin
      vbl_s1 <= vblank_pin;
      vbl_s2 <= vbl_s1;
      vbl_s3 <= vbl_s2;
      if (vbl_agree) begin
        vbl <= vbl_s3;
      end
    end
  end

  // ----------------------------------------
  // Frame control decode
  // ----------------------------------------
  wire frame_start = vbl_fall & ctrl[`CTRL_EN_BIT];
  wire prev_ok = (state == S_DONE) & ~lost;
  wire [15:0] total_blks = blks_row_act * rows_act;
  wire pending = (wr_bcount != rd_bcount);
  wire [COL_W-1:0] last_col = blks_row_act[COL_W-1:0] - 1'b1;
  // Entering a row that the writer still drains overwrites it
  wire lap = stat_wr & (wr_word == 4'h0) & (wr_col == {COL_W{1'b0}}) &
    pending & (wr_row == rd_row);
  wire emit = (state == S_HDR || state == S_TAIL ||
    (state == S_BLK && pending)) & ~mem_wr_full;
  wire blk_last = (rd_word == `BLK_OUT_WORDS - 5'h01);
  wire tail_last = (glob_idx == `TAIL_WORDS - 11'h001);
  wire [IDX_W-1:0] wr_idx = {wr_row, wr_col, wr_word};
  wire [4:0] rd_sub = rd_word - 5'h01;
  wire [IDX_W-1:0] rd_idx = {rd_row, rd_col, rd_sub[3:0]};
  wire done_set = emit & (state == S_TAIL) & tail_last;
  wire err_set = frame_start & frame_active & ~prev_ok;

  // ----------------------------------------
  // APB slave, one wait state per access
  // ----------------------------------------
  wire acc = psel & penable & ~pready;
  wire take_wr = psel & penable & pready & pwrite;
  reg [31:0] next_rdata;
  reg next_hit;

  always @* begin
    next_rdata = 32'h0000_0000;
    next_hit = 1'b1;
    case (paddr)
      `ADDR_CTRL: next_rdata[1:0] = ctrl;
      `ADDR_STAT_DONE: next_rdata[`STAT_FLAG_BIT] = stat_done;
      `ADDR_STAT_ERR: next_rdata[`STAT_FLAG_BIT] = stat_err;
      `ADDR_BLKS_ROW: next_rdata[7:0] = blks_row;
      `ADDR_ROWS: next_rdata[7:0] = rows;
      `ADDR_STATE: next_rdata = {lost, state, 12'h000, rd_bcount};
      default: next_hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~next_hit;
      if (acc & ~pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      blks_row <= `BLKS_ROW_RESET;
      rows <= `ROWS_RESET;
    end else if (take_wr) begin
      case (paddr)
        `ADDR_CTRL: ctrl <= pwdata[1:0];
        `ADDR_BLKS_ROW: blks_row <= pwdata[7:0];
        `ADDR_ROWS: rows <= pwdata[7:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Sticky status: a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_done <= 1'b0;
      stat_err <= 1'b0;
    end else begin
      if (done_set) begin
        stat_done <= 1'b1;
      end else if (take_wr && paddr == `ADDR_STAT_DONE) begin
        stat_done <= 1'b0;
      end
      if (err_set) begin
        stat_err <= 1'b1;
      end else if (take_wr && paddr == `ADDR_STAT_ERR) begin
        stat_err <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Double-buffered settings
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blks_row_act <= `BLKS_ROW_RESET;
      rows_act <= `ROWS_RESET;
      reg_update_done <= 1'b0;
    end else begin
      reg_update_done <= 1'b0;
      if (vbl_fall && ctrl[`CTRL_UPD_BIT]) begin
        blks_row_act <= blks_row;
        rows_act <= rows;
        reg_update_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Processor side of the two-row buffer
  // ----------------------------------------
  // Lines are fully buffered upstream: one result word per pixel cycle
  always @(posedge pclk) begin
    if (stat_wr) begin
      blk_buf[wr_idx] <= stat_wdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_word <= 4'h0;
      wr_col <= {COL_W{1'b0}};
      wr_row <= 1'b0;
      wr_bcount <= 16'h0000;
      lost <= 1'b0;
    end else if (frame_start) begin
      wr_word <= 4'h0;
      wr_col <= {COL_W{1'b0}};
      wr_row <= 1'b0;
      wr_bcount <= 16'h0000;
      lost <= 1'b0;
    end else if (stat_wr) begin
      if (lap) begin
        lost <= 1'b1;
      end
      wr_word <= wr_word + 4'h1;
      if (wr_word == `BLK_IN_WORDS - 5'h01) begin
        // Last pixel cycle of the block completes it
        wr_bcount <= wr_bcount + 16'h0001;
        if (wr_col == last_col) begin
          wr_col <= {COL_W{1'b0}};
          wr_row <= ~wr_row;
        end else begin
          wr_col <= wr_col + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Output writer
  // ----------------------------------------
  // Runs through all blanking, so idle line time drains the buffer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      frame_active <= 1'b0;
      rd_word <= 5'h00;
      rd_col <= {COL_W{1'b0}};
      rd_row <= 1'b0;
      rd_bcount <= 16'h0000;
      glob_idx <= 11'h000;
      mem_wr_en <= 1'b0;
      mem_wr_data <= 32'h0000_0000;
    end else begin
      mem_wr_en <= emit;
      if (frame_start) begin
        state <= S_HDR;
        frame_active <= 1'b1;
        rd_word <= 5'h00;
        rd_col <= {COL_W{1'b0}};
        rd_row <= 1'b0;
        rd_bcount <= 16'h0000;
        glob_idx <= 11'h000;
      end else begin
        case (state)
          S_HDR: begin
            if (emit) begin
              mem_wr_data <= `HDR_START;
              state <= S_BLK;
            end
          end
          S_BLK: begin
            if (rd_bcount == total_blks) begin
              state <= S_TAIL;
            end else if (emit) begin
              // Tag word then 16 result words: 17 cycles
              if (rd_word == 5'h00) begin
                mem_wr_data <= {`BLK_TAG, rd_bcount};
              end else begin
                mem_wr_data <= blk_buf[rd_idx];
              end
              rd_word <= rd_word + 5'h01;
              if (blk_last) begin
                rd_word <= 5'h00;
                rd_bcount <= rd_bcount + 16'h0001;
                if (rd_col == last_col) begin
                  rd_col <= {COL_W{1'b0}};
                  rd_row <= ~rd_row;
                end else begin
                  rd_col <= rd_col + 1'b1;
                end
              end
            end
          end
          S_TAIL: begin
            if (emit) begin
              glob_idx <= glob_idx + 11'h001;
              if (tail_last) begin
                mem_wr_data <= `HDR_FINAL;
                state <= S_DONE;
              end else begin
                mem_wr_data <= glob_data;
              end
            end
          end
          S_DONE: state <= S_DONE;
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Frame flags
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_done <= 1'b0;
      frame_error <= 1'b0;
      irq_event <= 2'h0;
    end else begin
      irq_event <= 2'h0;
      if (vbl_fall) begin
        frame_done <= 1'b0;
      end else if (done_set) begin
        frame_done <= 1'b1;
        irq_event[`IRQ_DONE_BIT] <= 1'b1;
      end
      if (err_set) begin
        frame_error <= 1'b1;
        irq_event[`IRQ_ERR_BIT] <= 1'b1;
      end else if (vbl_rise) begin
        frame_error <= 1'b0;
      end
    end
  end

endmodule // stats_output_writer

// ==== stats_writer_checker.sv ====
// Port checks of the statistics output writer
`include "stats_writer_defs.vh"
module stats_writer_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Frame timing and memory port
  input wire logic vblank_pin,
  input wire logic mem_wr_full,
  input wire logic mem_wr_en,
  input wire logic [31:0] mem_wr_data,
  // Frame flags
  input wire logic frame_done,
  input wire logic frame_error,
  input wire logic [1:0] irq_event,
  input wire logic reg_update_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_word;
  // Latest word, so done may coincide with the final header
  wire logic [31:0] seen_word = mem_wr_en ? mem_wr_data : last_word;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_word <= 32'h0;
    end else begin
      last_word <= seen_word;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_full_holds_off: assert property (mem_wr_full |=> !mem_wr_en)
    else $error("word written after full");
  a_done_irq_flag: assert property (irq_event[1] |-> ##[0:1] frame_done)
    else $error("completion event without done");
  a_err_irq_flag: assert property (irq_event[0] |-> ##[0:1] frame_error)
    else $error("error event without error flag");
  a_done_after_final: assert property (
    $rose(frame_done) |-> seen_word == `HDR_FINAL)
    else $error("done before final header");
  a_done_clear_low: assert property ($fell(frame_done) |-> !vblank_pin)
    else $error("done cleared outside blanking fall");
  a_err_clear_high: assert property ($fell(frame_error) |-> vblank_pin)
    else $error("error cleared while blanking low");
  a_err_set_low: assert property ($rose(frame_error) |-> !vblank_pin)
    else $error("error raised outside frame start");
  a_update_at_start: assert property (reg_update_done |-> !vblank_pin)
    else $error("settings loaded outside frame start");
endmodule // stats_writer_checker

bind stats_output_writer stats_writer_checker i_stats_writer_checker (
  .pclk, .presetn, .vblank_pin, .mem_wr_full, .mem_wr_en, .mem_wr_data,
  .frame_done, .frame_error, .irq_event, .reg_update_done);

// ==== mem_port_model.sv ====
// Memory controller write port model with commanded back-pressure
module mem_port_model (
  // Clock and stall command
  input wire logic pclk,
  input wire logic hold,
  // Write port
  input wire logic mem_wr_en,
  input wire logic [31:0] mem_wr_data,
  output logic mem_wr_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] words[$];
  // Full is registered, so it follows the hold command one cycle late
  always @(posedge pclk) begin
    mem_wr_full <= hold;
    if (mem_wr_en === 1'b1) begin
      words.push_back(mem_wr_data);
    end
  end
endmodule // mem_port_model

// ==== stats_output_writer_bench.sv ====
// Self-checking bench of the statistics output writer
`include "stats_writer_defs.vh"
module stats_output_writer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, vblank_pin = 1'b0, stat_wr = 1'b0, hold = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, stat_wdata = 32'h0, q;
  logic e;
  wire [31:0] prdata, mem_wr_data;
  wire pready, pslverr, mem_wr_full, mem_wr_en, frame_done, frame_error;
  wire reg_update_done;
  wire [1:0] irq_event;
  wire [10:0] glob_idx;
  wire [31:0] glob_data = {21'h0a5a5a, glob_idx};
  int failures = 0, n_checks = 0, cyc = 0, u;
  always #12.5 pclk = ~pclk;
  stats_output_writer i_stats_output_writer (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .vblank_pin, .stat_wr, .stat_wdata, .glob_data, .glob_idx,
    .mem_wr_full, .mem_wr_en, .mem_wr_data, .frame_done, .frame_error,
    .irq_event, .reg_update_done);
  mem_port_model i_mem_port_model (.pclk, .hold, .mem_wr_en, .mem_wr_data,
    .mem_wr_full);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h", $time, m, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, string m);
    apb(1'b0, a, 32'h0);
    chk(q, x, m);
    chk({31'h0, e}, 32'h0, "slverr");
  endtask
  // Frame: blanking fall, 16 blocks of 16 words, gap after each row
  task automatic frame(input int gap);
    vblank_pin <= 1'b0;
    u = 0;
    repeat (8) begin
      @(posedge pclk);
      if (reg_update_done === 1'b1) u++;
    end
    e = frame_error;
    for (int b = 0; b < 16; b++) begin
      for (int w = 0; w < 16; w++) begin
        stat_wr <= 1'b1;
        stat_wdata <= {24'h0, b[3:0], w[3:0]};
        @(posedge pclk);
      end
      if (b % 4 == 3) begin
        stat_wr <= 1'b0;
        repeat (gap) @(posedge pclk);
      end
    end
    vblank_pin <= 1'b1;
  endtask
  task automatic wait_done();
    for (int n = 0; n < 3000 && frame_done !== 1'b1; n++) @(posedge pclk);
    // Let the port model take the closing word
    repeat (2) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ADDR_CTRL, 32'h1, "ctrl reset");
    rd(`ADDR_BLKS_ROW, 32'h4, "blocks reset");
    rd(`ADDR_STAT_DONE, 32'h0, "done status reset");
    apb(1'b1, 8'h18, 32'h5);
    apb(1'b0, 8'h18, 32'h0);
    chk({q[31:1], e}, 32'h1, "unmapped read");
    vblank_pin <= 1'b1;
    repeat (20) @(posedge pclk);
    frame(`HBLANK_MIN_CYCLES);
    chk(u, 0, "first frame flags");
    wait_done();
    chk(frame_done, 1'b1, "frame done");
    chk(i_mem_port_model.words.size(), 1361, "word count");
    chk(i_mem_port_model.words[0], `HDR_START, "start header");
    for (int b = 0; b < 16; b++) begin
      chk(i_mem_port_model.words[17 * b + 1], {`BLK_TAG, 16'(b)}, "tag");
      for (int w = 0; w < 16; w++) begin
        chk(i_mem_port_model.words[17 * b + w + 2],
          {24'h0, 4'(b), 4'(w)}, "result");
      end
    end
    for (int k = 0; k < 1087; k++) begin
      chk(i_mem_port_model.words[273 + k], {21'h0a5a5a, 11'(k)}, "tail");
    end
    chk(i_mem_port_model.words[1360], `HDR_FINAL, "final header");
    rd(`ADDR_STAT_DONE, 32'h1, "done status set");
    apb(1'b1, `ADDR_STAT_DONE, 32'ha5);
    rd(`ADDR_STAT_DONE, 32'h0, "done status clear");
    apb(1'b1, `ADDR_CTRL, 32'h3);
    i_mem_port_model.words.delete();
    hold <= 1'b1;
    frame(`HBLANK_MIN_CYCLES);
    chk({frame_done, e}, 2'b00, "done cleared, no error");
    chk(u, 1, "settings loaded");
    chk(i_mem_port_model.words.size(), 0, "stalled port");
    hold <= 1'b0;
    repeat (2500) @(posedge pclk);
    frame(10);
    chk(e, 1'b1, "lapped frame error");
    chk(frame_error, 1'b1, "error held in frame");
    rd(`ADDR_STAT_ERR, 32'h1, "error status set");
    apb(1'b1, `ADDR_STAT_ERR, 32'h0);
    rd(`ADDR_STAT_ERR, 32'h0, "error status clear");
    repeat (8) @(posedge pclk);
    chk(frame_error, 1'b0, "error cleared at blanking");
    wait_done();
    end_of_test();
  end
endmodule // stats_output_writer_bench
